/* core/cpsf_top.sv */
// camera parallel to serial framer with apb control
// ==================================================
// Overview of operation
// - each pixel byte is captured on the falling edge of the pixel clock.
// - frame and line valid edges decide where sync codes go around the pixel bytes.
// - the lane sends eight bits per pixel clock, one byte per pixel period.
// - with the line limit on, lines are counted and the limit line ends with a frame end.
// - the line count stops at 2046 and with the line limit on any further line in the frame is an error.
// - the lane shuts down while transmit enable or the soft enable is low and wakes when both are high.
// - the lane goes to standby when the pixel clock stops and resumes when it runs.
// - pixel bytes pass unchanged whatever the image format, save the lsb set to break a sync imitation.
// - serial data changes on the falling edge of the lane clock, lsb first.
// - sync codes are ff000000, ff000001, ff000002 and ff000003, sent bytewise, most significant byte first.
// - during line and frame blanking the data lane is held high.
// - eight ones followed by sixteen zeros in pixel data set the lsb of the third byte.
`default_nettype none
`include "cpsf_params.svh"
module cpsf_top (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CPSF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pixel_clock_in,
  input wire logic frame_valid,
  input wire logic line_valid,
  input wire logic [`CPSF_BYTE_W-1:0] parallel_pixel_bus,
  input wire logic transmit_enable_pin,
  output logic serial_data_out,
  output logic lane_clock_enable
);
  localparam logic [`CPSF_IDLE_CNT_W-1:0] STANDBY_CNT = `CPSF_IDLE_CNT_W'(`CPSF_STANDBY_CYCLES);

  function automatic logic [`CPSF_BYTE_W-1:0] code_byte(input logic [`CPSF_CODE_W-1:0] c,
                                                        input logic [1:0] i);
    logic [`CPSF_CODE_W-1:0] t;
    t = c << {i, 3'h0};
    return t[`CPSF_CODE_W-1 -: `CPSF_BYTE_W];
  endfunction

  // w holds four bytes in send order, first byte in the low bits
  function automatic logic esc_match(input logic [`CPSF_CODE_W-1:0] w, input logic last_valid);
    logic hit;
    hit = 1'b0;
    for (int p = 0; p < `CPSF_BYTE_W; p++) begin
      if (w[p +: `CPSF_ESC_SPAN] == `CPSF_ESC_ONES && (p == 0 || last_valid)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ==================================================
  // pixel domain, clocked on the falling pixel edge
  logic pix_clk_n;
  logic pix_rst_n;
  logic pix_en;
  logic pix_lim;
  logic tx_en_reg;
  logic ctrl_lim_reg;
  assign pix_clk_n = ~pixel_clock_in;

  cpsf_sync #(.W(1)) u_pix_rst (
    .clock(pix_clk_n),
    .arst_n(arst_n),
    .d(1'b1),
    .q(pix_rst_n)
  );

  cpsf_sync #(.W(2)) u_pix_ctl (
    .clock(pix_clk_n),
    .arst_n(pix_rst_n),
    .d({tx_en_reg, ctrl_lim_reg}),
    .q({pix_en, pix_lim})
  );

  logic fv_reg;
  logic lv_reg;
  logic lv_d_reg;
  logic [`CPSF_BYTE_W-1:0] din_reg;

  always_ff @(posedge pix_clk_n or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      fv_reg <= 1'b0;
      lv_reg <= 1'b0;
      lv_d_reg <= 1'b0;
      din_reg <= '0;
    end else begin
      fv_reg <= frame_valid;
      lv_reg <= line_valid;
      lv_d_reg <= lv_reg;
      din_reg <= parallel_pixel_bus;
    end
  end

  cpsf_pkg::cpsf_state_t st_reg;
  cpsf_pkg::cpsf_pix_t stage_reg [`CPSF_STAGES];
  logic [1:0] cnt_reg;
  logic [`CPSF_CODE_W-1:0] code_reg;
  logic [`CPSF_BYTE_W-1:0] out_byte_reg;
  logic out_tog_reg;
  logic frame_open_reg;
  logic closed_reg;
  logic lim_err_reg;
  logic [`CPSF_LINE_CNT_W-1:0] line_cnt_reg;

  logic in_valid;
  logic line_rise;
  logic esc;
  logic start_line;
  logic solo_end;
  logic line_done;
  logic lim_hit;
  logic end_frame;
  // lv is only honoured inside a frame; the camera keeps it low outside
  assign in_valid = lv_reg & fv_reg & pix_en & ~closed_reg;
  assign line_rise = in_valid & ~lv_d_reg;
  // sync imitation check over four bytes
  assign esc = stage_reg[2].valid & stage_reg[1].valid & stage_reg[0].valid &
               esc_match({din_reg, stage_reg[0].data, stage_reg[1].data, stage_reg[2].data},
                         in_valid);
  assign start_line = st_reg == cpsf_pkg::ST_IDLE && line_rise;
  assign solo_end = st_reg == cpsf_pkg::ST_IDLE && !line_rise && frame_open_reg && !fv_reg;
  assign line_done = st_reg == cpsf_pkg::ST_BODY && !lv_reg && !stage_reg[0].valid &&
                     !stage_reg[1].valid && !stage_reg[2].valid;
  assign lim_hit = pix_lim && line_cnt_reg == `CPSF_LINE_MAX - `CPSF_LINE_CNT_W'(1);
  assign end_frame = lim_hit | ~fv_reg;

  // four byte delay leaves room for the line head code
  always_ff @(posedge pix_clk_n or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      for (int i = 0; i < `CPSF_STAGES; i++) begin
        stage_reg[i] <= '0;
      end
    end else begin
      stage_reg[0] <= '{valid: in_valid, data: din_reg};
      // set lsb of trailing zero byte
      stage_reg[1] <= '{valid: stage_reg[0].valid,
                        data: stage_reg[0].data | (esc ? `CPSF_ESC_BIT : '0)};
      stage_reg[2] <= stage_reg[1];
      stage_reg[3] <= stage_reg[2];
    end
  end

  always_ff @(posedge pix_clk_n or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      st_reg <= cpsf_pkg::ST_IDLE;
      cnt_reg <= '0;
      code_reg <= `CPSF_CODE_LS;
      out_byte_reg <= `CPSF_IDLE_BYTE;
    end else if (!pix_en) begin
      st_reg <= cpsf_pkg::ST_IDLE;
      cnt_reg <= '0;
      out_byte_reg <= `CPSF_IDLE_BYTE;
    end else begin
      case (st_reg)
        cpsf_pkg::ST_IDLE: begin
          out_byte_reg <= `CPSF_IDLE_BYTE;
          cnt_reg <= 2'h1;
          if (start_line) begin
            // first line opens with frame start
            code_reg <= frame_open_reg ? `CPSF_CODE_LS : `CPSF_CODE_FS;
            out_byte_reg <= code_byte(frame_open_reg ? `CPSF_CODE_LS : `CPSF_CODE_FS, 2'h0);
            st_reg <= cpsf_pkg::ST_HEAD;
          end else if (solo_end) begin
            code_reg <= `CPSF_CODE_FE;
            out_byte_reg <= code_byte(`CPSF_CODE_FE, 2'h0);
            st_reg <= cpsf_pkg::ST_TAIL;
          end
        end
        cpsf_pkg::ST_HEAD: begin
          out_byte_reg <= code_byte(code_reg, cnt_reg);
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == `CPSF_CODE_LAST) begin
            st_reg <= cpsf_pkg::ST_BODY;
          end
        end
        cpsf_pkg::ST_BODY: begin
          out_byte_reg <= stage_reg[3].valid ? stage_reg[3].data : `CPSF_IDLE_BYTE;
          cnt_reg <= '0;
          if (line_done) begin
            // last line closes with frame end
            code_reg <= end_frame ? `CPSF_CODE_FE : `CPSF_CODE_LE;
            st_reg <= cpsf_pkg::ST_TAIL;
          end
        end
        cpsf_pkg::ST_TAIL: begin
          out_byte_reg <= code_byte(code_reg, cnt_reg);
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == `CPSF_CODE_LAST) begin
            st_reg <= cpsf_pkg::ST_IDLE;
          end
        end
        default: begin
          st_reg <= cpsf_pkg::ST_IDLE;
          out_byte_reg <= `CPSF_IDLE_BYTE;
        end
      endcase
    end
  end

  // toggles every pixel period: byte strobe and pixel clock heartbeat
  always_ff @(posedge pix_clk_n or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      out_tog_reg <= 1'b0;
    end else begin
      out_tog_reg <= ~out_tog_reg;
    end
  end

  always_ff @(posedge pix_clk_n or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      frame_open_reg <= 1'b0;
      closed_reg <= 1'b0;
      line_cnt_reg <= '0;
    end else if (!pix_en) begin
      frame_open_reg <= 1'b0;
      closed_reg <= 1'b0;
      line_cnt_reg <= '0;
    end else if (start_line) begin
      frame_open_reg <= 1'b1;
      // short frame blanking can skip the idle clear
      if (!frame_open_reg) begin
        line_cnt_reg <= '0;
      end
    end else if (solo_end) begin
      frame_open_reg <= 1'b0;
    end else if (line_done) begin
      if (line_cnt_reg != `CPSF_LINE_MAX) begin
        line_cnt_reg <= line_cnt_reg + `CPSF_LINE_CNT_W'(1);
      end
      frame_open_reg <= ~end_frame;
      closed_reg <= lim_hit;
    end else if (st_reg == cpsf_pkg::ST_IDLE && !fv_reg) begin
      closed_reg <= 1'b0;
      line_cnt_reg <= '0;
    end
  end

  always_ff @(posedge pix_clk_n or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      lim_err_reg <= 1'b0;
    end else if (closed_reg && fv_reg && lv_reg && !lv_d_reg) begin
      lim_err_reg <= 1'b1;
    end else if (start_line && !frame_open_reg) begin
      lim_err_reg <= 1'b0;
    end
  end

  // ==================================================
  // system clock domain: bus, enable and lane
  logic pin_s;
  logic frame_open_s;
  logic lim_err_s;
  logic tog_s;
  logic tog_d_reg;
  logic tog_edge;
  logic ctrl_en_reg;
  logic [`CPSF_IDLE_CNT_W-1:0] idle_cnt_reg;
  logic standby;
  logic active;
  logic [`CPSF_BYTE_W-1:0] hold_reg;
  logic [`CPSF_BYTE_W-1:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic dout_reg;
  logic lane_en_reg;
  cpsf_pkg::cpsf_status_t status;

  cpsf_sync #(.W(1)) u_pin_sync (
    .clock(clock),
    .arst_n(arst_n),
    .d(transmit_enable_pin),
    .q(pin_s)
  );

  cpsf_sync #(.W(3)) u_stat_sync (
    .clock(clock),
    .arst_n(arst_n),
    .d({frame_open_reg, lim_err_reg, out_tog_reg}),
    .q({frame_open_s, lim_err_s, tog_s})
  );

  assign tog_edge = tog_s ^ tog_d_reg;
  assign standby = idle_cnt_reg >= STANDBY_CNT;
  assign active = tx_en_reg & ~standby;
  assign status = '{pin_enable: pin_s, shutdown: ~tx_en_reg, standby: standby,
                    frame_open: frame_open_s, limit_error: lim_err_s};

  // no wait state; read data comes from a flop loaded in the setup cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= psel & ~penable;
      pslverr_reg <= psel & ~penable & (paddr != `CPSF_ADDR_CTRL) & (paddr != `CPSF_ADDR_STAT);
      prdata_reg <= '0;
      if (psel && !penable && paddr == `CPSF_ADDR_CTRL) begin
        prdata_reg[`CPSF_CTRL_EN_BIT] <= ctrl_en_reg;
        prdata_reg[`CPSF_CTRL_LIM_BIT] <= ctrl_lim_reg;
      end else if (psel && !penable && paddr == `CPSF_ADDR_STAT) begin
        prdata_reg[`CPSF_STAT_W-1:0] <= status;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_en_reg <= `CPSF_CTRL_EN_RST;
      ctrl_lim_reg <= `CPSF_CTRL_LIM_RST;
    end else if (psel && penable && pready_reg && pwrite && paddr == `CPSF_ADDR_CTRL) begin
      ctrl_en_reg <= pwdata[`CPSF_CTRL_EN_BIT];
      ctrl_lim_reg <= pwdata[`CPSF_CTRL_LIM_BIT];
    end
  end

  // shutdown follows the pin and soft enable
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_en_reg <= 1'b0;
    end else begin
      tx_en_reg <= pin_s & ctrl_en_reg;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tog_d_reg <= 1'b0;
      idle_cnt_reg <= STANDBY_CNT;
    end else begin
      tog_d_reg <= tog_s;
      if (tog_edge) begin
        idle_cnt_reg <= '0;
      end else if (!standby) begin
        idle_cnt_reg <= idle_cnt_reg + `CPSF_IDLE_CNT_W'(1);
      end
    end
  end

  // byte is stable for a whole pixel period around its toggle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hold_reg <= `CPSF_IDLE_BYTE;
    end else if (tog_edge) begin
      hold_reg <= out_byte_reg;
    end
  end

  // eight bits per byte, free running
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_reg <= '0;
      shift_reg <= `CPSF_IDLE_BYTE;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == `CPSF_BIT_LAST) begin
        shift_reg <= active ? hold_reg : `CPSF_IDLE_BYTE;
      end else begin
        shift_reg <= {1'b1, shift_reg[`CPSF_BYTE_W-1:1]};
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lane_en_reg <= 1'b0;
    end else begin
      lane_en_reg <= active;
    end
  end

  // data moves on the falling edge, lsb first
  always_ff @(negedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dout_reg <= 1'b0;
    end else begin
      dout_reg <= tx_en_reg & (standby | shift_reg[0]);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign serial_data_out = dout_reg;
  assign lane_clock_enable = lane_en_reg;

  // ==================================================
  // checks
  capture_edge_a: assert property (
    @(posedge pix_clk_n) disable iff (!pix_rst_n)
    1'b1 |=> din_reg == $past(parallel_pixel_bus))
    else $error("pixel byte not captured on falling edge");
  head_code_a: assert property (
    @(posedge pix_clk_n) disable iff (!pix_rst_n)
    start_line && pix_en |=> out_byte_reg == 8'hff ##1 out_byte_reg == 8'h00
      ##1 out_byte_reg == 8'h00 ##1 out_byte_reg[7:2] == 6'h00)
    else $error("head code bytes wrong");
  first_line_a: assert property (
    @(posedge pix_clk_n) disable iff (!pix_rst_n)
    start_line && pix_en && !frame_open_reg |-> ##4 out_byte_reg == 8'h02)
    else $error("first line lacks frame start");
  blank_high_a: assert property (
    @(posedge pix_clk_n) disable iff (!pix_rst_n)
    st_reg == cpsf_pkg::ST_IDLE && !start_line && !solo_end |=> out_byte_reg == 8'hff)
    else $error("blanking byte not all ones");
  pass_through_a: assert property (
    @(posedge pix_clk_n) disable iff (!pix_rst_n)
    pix_en && st_reg == cpsf_pkg::ST_BODY && stage_reg[3].valid
      |=> out_byte_reg == $past(stage_reg[3].data))
    else $error("pixel byte altered");
  escape_set_a: assert property (
    @(posedge pix_clk_n) disable iff (!pix_rst_n)
    esc |=> stage_reg[1].data[0] && stage_reg[2] == $past(stage_reg[1]))
    else $error("sync imitation not broken");
  limit_end_a: assert property (
    @(posedge pix_clk_n) disable iff (!pix_rst_n)
    $rose(closed_reg) |-> code_reg == 32'hff000003 && line_cnt_reg == `CPSF_LINE_MAX)
    else $error("limit line not closed by frame end");
  line_cap_a: assert property (
    @(posedge pix_clk_n) disable iff (!pix_rst_n)
    line_cnt_reg <= `CPSF_LINE_MAX)
    else $error("line count beyond limit");
  byte_period_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    bit_cnt_reg == 3'h7 |=> bit_cnt_reg == 3'h0 ##7 bit_cnt_reg == 3'h7)
    else $error("byte period not eight bits");
  lsb_order_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    // dout was loaded half a cycle ago from the shifter as it stands now
    $past(active) && active |-> dout_reg == shift_reg[0])
    else $error("serial bit not lsb of shifter");
  shutdown_low_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    !tx_en_reg [*2] |-> !dout_reg && !lane_en_reg)
    else $error("lane active in shutdown");
  standby_off_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    standby |=> !lane_en_reg ##1 (lane_en_reg == $past(active)))
    else $error("lane clock runs in standby");
endmodule // cpsf_top
`default_nettype wire

/* core/cpsf_params.svh */
// constants of the camera parallel to serial framer
`ifndef CPSF_PARAMS_SVH
`define CPSF_PARAMS_SVH
// ==================================================
// stream format
`define CPSF_BYTE_W 8
`define CPSF_CODE_W 32
`define CPSF_CODE_LS 32'hff000000
`define CPSF_CODE_LE 32'hff000001
`define CPSF_CODE_FS 32'hff000002
`define CPSF_CODE_FE 32'hff000003
`define CPSF_CODE_LAST 2'h3
`define CPSF_IDLE_BYTE 8'hff
`define CPSF_ESC_BIT 8'h01
`define CPSF_ESC_ONES 24'h0000ff
`define CPSF_ESC_SPAN 24
`define CPSF_STAGES 4
`define CPSF_BIT_LAST 3'h7
// ==================================================
// frame line limit
`define CPSF_LINE_CNT_W 11
`define CPSF_LINE_MAX 11'h7fe
// ==================================================
// timing
`define CPSF_CLK_PERIOD_NS 8
`define CPSF_STANDBY_NS 512
`define CPSF_STANDBY_CYCLES ((`CPSF_STANDBY_NS + `CPSF_CLK_PERIOD_NS - 1) / `CPSF_CLK_PERIOD_NS)
`define CPSF_IDLE_CNT_W 8
// ==================================================
// register map
`define CPSF_ADDR_W 12
`define CPSF_ADDR_CTRL 12'h000
`define CPSF_ADDR_STAT 12'h004
`define CPSF_CTRL_EN_BIT 0
`define CPSF_CTRL_LIM_BIT 1
`define CPSF_CTRL_EN_RST 1'b1
`define CPSF_CTRL_LIM_RST 1'b0
`define CPSF_STAT_W 5
`endif

/* core/cpsf_pkg.sv */
// types of the camera parallel to serial framer
`default_nettype none
`include "cpsf_params.svh"
package cpsf_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HEAD,
    ST_BODY,
    ST_TAIL
  } cpsf_state_t;

  typedef struct packed {
    logic valid;
    logic [`CPSF_BYTE_W-1:0] data;
  } cpsf_pix_t;

  typedef struct packed {
    logic pin_enable;
    logic shutdown;
    logic standby;
    logic frame_open;
    logic limit_error;
  } cpsf_status_t;
endpackage
`default_nettype wire

/* core/cpsf_sync.sv */
// two flop level synchroniser
`default_nettype none
module cpsf_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule // cpsf_sync
`default_nettype wire

/* verification/cpsf_rx_model.sv */
// behavioural host receiver of the serial lane
`default_nettype none
module cpsf_rx_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic lane_clock_enable,
  input wire logic serial_data_out,
  output logic got,
  output logic got_code,
  output logic [7:0] got_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] hist;
  logic [2:0] nbit;
  logic want;
  logic inl;
  // two bytes held back so a tail code is never reported as pixels
  logic [7:0] hold[$];
  // =====
  // bit sampling and framing
  always @(posedge clock or negedge arst_n) begin : rx
    logic [31:0] h;
    if (!arst_n) begin
      hist <= 32'h0;
      nbit <= 3'h0;
      want <= 1'b0;
      inl <= 1'b0;
      got <= 1'b0;
      got_code <= 1'b0;
      got_byte <= 8'h00;
      hold.delete();
    end else begin
      got <= 1'b0;
      if (lane_clock_enable) begin
        h = {serial_data_out, hist[31:1]};
        hist <= h;
        nbit <= nbit + 3'h1;
        if (h[31:8] == 24'h0000ff) begin
          want <= 1'b1;
          nbit <= 3'h0;
          hold.delete();
        end else if (nbit == 3'h7 && want) begin
          want <= 1'b0;
          got <= 1'b1;
          got_code <= 1'b1;
          got_byte <= h[31:24];
          inl <= !h[24];
        end else if (nbit == 3'h7 && inl) begin
          if (hold.size() == 2) begin
            got <= 1'b1;
            got_code <= 1'b0;
            got_byte <= hold.pop_front();
          end
          hold.push_back(h[31:24]);
        end
      end
    end
  end
endmodule // cpsf_rx_model
`default_nettype wire

/* verification/tb.sv */
// self-checking bench of the camera serial framer
`default_nettype none
`include "cpsf_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [`CPSF_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pixel_clock_in, frame_valid, line_valid, transmit_enable_pin;
  logic [7:0] parallel_pixel_bus, rx_byte;
  logic serial_data_out, lane_clock_enable, rx_got, rx_code;
  bit prev_pix;
  logic pix_run = 1'b1;
  int err_count, tests_run, cyc, seed;
  time last_t;
  logic [8:0] exp_q[$];
  cpsf_top cpsf_top_i (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pixel_clock_in(pixel_clock_in), .frame_valid(frame_valid),
    .line_valid(line_valid), .parallel_pixel_bus(parallel_pixel_bus),
    .transmit_enable_pin(transmit_enable_pin), .serial_data_out(serial_data_out),
    .lane_clock_enable(lane_clock_enable));
  cpsf_rx_model cpsf_rx_model_i (.clock(clock), .arst_n(arst_n),
    .lane_clock_enable(lane_clock_enable), .serial_data_out(serial_data_out),
    .got(rx_got), .got_code(rx_code), .got_byte(rx_byte));
  // =====
  // clocks
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // pixel clock stands still while pix_run is low
  initial begin
    pixel_clock_in = 1'b0;
    #3;
    forever begin
      #32;
      if (pix_run) pixel_clock_in = ~pixel_clock_in;
    end
  end
  // =====
  // reporting
  task automatic fail(input string m);
    err_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) fail($sformatf("word %h want %h", g, x));
  endtask
  task automatic cmp_bit(input logic g, input logic x);
    tests_run++;
    if (g !== x) fail($sformatf("level %b want %b", g, x));
  endtask
  task automatic cmp_ev(input logic [8:0] g, input logic [8:0] x);
    tests_run++;
    if (g !== x) fail($sformatf("stream %h want %h", g, x));
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fail("timeout");
      summarize();
    end
  end
  // =====
  // stream comparison
  always @(posedge clock) begin
    if (rx_got) begin
      if (!rx_code && prev_pix) cmp_word(32'($time - last_t), 32'h40);
      prev_pix = !rx_code;
      last_t = $time;
      if (exp_q.size() == 0) fail("extra stream byte");
      else cmp_ev({rx_code, rx_byte}, exp_q.pop_front());
    end
  end
  // =====
  // apb master
  task automatic apb(input logic w, input logic [`CPSF_ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [31:0] xr, input logic xe);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    if (!w) cmp_word(prdata, xr);
    cmp_bit(pslverr, xe);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // =====
  // camera side
  // strobes move on rising edge
  task automatic send_line(input logic [7:0] d[$], input logic [7:0] e[$], input bit f,
                           input bit l);
    exp_q.push_back({1'b1, f ? 8'h02 : 8'h00});
    foreach (e[i]) exp_q.push_back({1'b0, e[i]});
    exp_q.push_back({1'b1, l ? 8'h03 : 8'h01});
    foreach (d[i]) begin
      @(posedge pixel_clock_in);
      line_valid <= 1'b1;
      parallel_pixel_bus <= d[i];
    end
    @(posedge pixel_clock_in);
    line_valid <= 1'b0;
    if (l) frame_valid <= 1'b0;
    repeat (8) @(posedge pixel_clock_in);
  endtask
  // bit 4 forced high keeps random data clear of the escape pattern
  task automatic rand_frame(input int nl);
    logic [7:0] d[$];
    int n;
    @(posedge pixel_clock_in);
    frame_valid <= 1'b1;
    repeat (3) @(posedge pixel_clock_in);
    for (int k = 0; k < nl; k++) begin
      d.delete();
      n = 1 + ($unsigned($random(seed)) % 6);
      repeat (n) d.push_back(8'($random(seed)) | 8'h10);
      send_line(d, d, k == 0, k == nl - 1);
    end
  endtask
  // =====
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {frame_valid, line_valid, parallel_pixel_bus} = '0;
    transmit_enable_pin = 1'b1;
    arst_n = 1'b0;
    seed = 7159;
    repeat (4) @(posedge pixel_clock_in);
    cmp_bit(lane_clock_enable, 1'b0);
    cmp_bit(serial_data_out, 1'b0);
    @(posedge clock);
    arst_n <= 1'b1;
    apb(1'b0, `CPSF_ADDR_CTRL, 32'h0, 32'h1, 1'b0);
    repeat (100) @(posedge clock);
    apb(1'b1, `CPSF_ADDR_CTRL, 32'h3, 32'h0, 1'b0);
    apb(1'b0, `CPSF_ADDR_CTRL, 32'h0, 32'h3, 1'b0);
    apb(1'b1, `CPSF_ADDR_STAT, 32'h1f, 32'h0, 1'b0);
    apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
    apb(1'b0, `CPSF_ADDR_STAT, 32'h0, 32'h10, 1'b0);
    cmp_bit(serial_data_out, 1'b1);
    cmp_bit(lane_clock_enable, 1'b1);
    rand_frame(4);
    frame_valid <= 1'b1;
    send_line('{8'hff, 8'h00, 8'h00, 8'h00, 8'hfe, 8'h01, 8'h00, 8'h00},
              '{8'hff, 8'h00, 8'h01, 8'h00, 8'hfe, 8'h01, 8'h01, 8'h00}, 1, 1);
    // two rgb 565 pixels, then u y v y
    frame_valid <= 1'b1;
    send_line('{8'hff, 8'hff, 8'h01, 8'h81}, '{8'hff, 8'hff, 8'h01, 8'h81}, 1, 0);
    send_line('{8'h80, 8'h10, 8'h80, 8'heb}, '{8'h80, 8'h10, 8'h80, 8'heb}, 0, 1);
    repeat (200) @(posedge clock);
    cmp_word(exp_q.size(), 32'h0);
    transmit_enable_pin <= 1'b0;
    repeat (20) @(posedge clock);
    cmp_bit(serial_data_out, 1'b0);
    cmp_bit(lane_clock_enable, 1'b0);
    apb(1'b0, `CPSF_ADDR_STAT, 32'h0, 32'h08, 1'b0);
    transmit_enable_pin <= 1'b1;
    repeat (20) @(posedge clock);
    cmp_bit(lane_clock_enable, 1'b1);
    apb(1'b1, `CPSF_ADDR_CTRL, 32'h2, 32'h0, 1'b0);
    repeat (10) @(posedge clock);
    cmp_bit(lane_clock_enable, 1'b0);
    apb(1'b1, `CPSF_ADDR_CTRL, 32'h3, 32'h0, 1'b0);
    repeat (20) @(posedge clock);
    pix_run <= 1'b0;
    repeat (100) @(posedge clock);
    cmp_bit(lane_clock_enable, 1'b0);
    cmp_bit(serial_data_out, 1'b1);
    apb(1'b0, `CPSF_ADDR_STAT, 32'h0, 32'h14, 1'b0);
    pix_run <= 1'b1;
    repeat (100) @(posedge clock);
    cmp_bit(lane_clock_enable, 1'b1);
    rand_frame(3);
    repeat (200) @(posedge clock);
    cmp_word(exp_q.size(), 32'h0);
    summarize();
  end
endmodule // tb
`default_nettype wire
